// File: shared/npbr_pkg.sv
package npbr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PAGE_COUNT = 8'h00;
  localparam logic [7:0] OFS_BB_FIRST = 8'h04;
  localparam logic [7:0] OFS_BB_SECOND = 8'h08;
  localparam logic [7:0] OFS_RET_DELAY = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  // Page counter fields
  localparam int CNT_W = 6;
  localparam int CNT0_LSB = 0;
  localparam int CNT1_LSB = 16;
  // Return-delay fields
  localparam int STAGES = 8;
  localparam int STAGE_W = 3;
  localparam int SEL_LSB = 24;
  localparam int SEL_W = 4;
  localparam logic [31:0] RET_DELAY_MASK = 32'h0fff_ffff;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // Status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_BB0 = 0;
  localparam int IRQ_BB1 = 1;
  localparam int IRQ_PG0 = 2;
  localparam int IRQ_PG1 = 3;
  // Tap select: 0 means no delay, 8..15 pick stage 1..8
  localparam logic [3:0] SEL_FIRST_STAGE = 4'h8;
endpackage

// File: rtl/npbr_page_counter.sv
`timescale 1ns/1ps
`default_nettype none
module npbr_page_counter #(
  parameter int W = 6
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cmd_start,
  input wire logic page_done,
  output logic [W-1:0] count_q
);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (cmd_start) begin
      count_q <= '0;
    end else if (page_done) begin
      count_q <= count_q + W'(1);
    end
  end
endmodule
`default_nettype wire

// File: rtl/npbr_delay_chain.sv
`timescale 1ns/1ps
`default_nettype none
module npbr_delay_chain #(
  parameter int STAGES = 8,
  parameter int STAGE_W = 3,
  parameter int SEL_W = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic strobe_in,
  input wire logic [STAGES*STAGE_W-1:0] stage_set,
  input wire logic [SEL_W-1:0] tap_sel,
  output logic latch_edge
);
  // Cycle-level model of analog stages: each stage is a base
  // register plus up to 7 extra taps, so delay rises monotonically.
  localparam int DEPTH = 1 << STAGE_W;
  logic [STAGES-1:0] stage_out;
  logic [STAGES*DEPTH-1:0] pipe_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pipe_q <= '0;
    end else begin
      for (int s = 0; s < STAGES; s++) begin
        pipe_q[s*DEPTH] <= (s == 0) ? strobe_in : stage_out[(s+7)%8];
        for (int k = 1; k < DEPTH; k++) begin
          pipe_q[s*DEPTH+k] <= pipe_q[s*DEPTH+k-1];
        end
      end
    end
  end

  always_comb begin
    for (int s = 0; s < STAGES; s++) begin
      stage_out[s] = pipe_q[s*DEPTH + int'(stage_set[s*STAGE_W +: STAGE_W])];
    end
  end

  always_comb begin
    if (!tap_sel[SEL_W-1]) begin
      latch_edge = strobe_in;
    end else begin
      latch_edge = stage_out[tap_sel[SEL_W-2:0]];
    end
  end
endmodule
`default_nettype wire

// File: rtl/npbr_regs.sv
// Summary of operation
// - Readable pages-done count per multi-page command
// - Page-count register ignores writes
// - Counters at bits 21:16 and 5:0
// - First bad-block capture with its flag
// - Second bad-block capture with its flag
// - Capture registers read-only, reset zero
// - Software-programmed read-strobe latch delay
// - Eight cascaded delay stages, tap selectable
// - Bits 27:24 select latching stage
// - Bits 23:0 hold eight stage settings
// - Bits 31:28 reserved
// - All-zero means no added delay
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module npbr_regs #(
  parameter int CNT_W = npbr_pkg::CNT_W
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_start_first,
  input wire logic cmd_start_second,
  input wire logic page_done_first,
  input wire logic page_done_second,
  input wire logic bad_block_first,
  input wire logic bad_block_second,
  input wire logic [31:0] addr_cycles,
  input wire logic read_strobe_n,
  output logic latch_edge,
  output logic bad_block_flag_first,
  output logic bad_block_flag_second,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  logic access;
  logic wr;
  logic [CNT_W-1:0] pages_done_first_select;
  logic [CNT_W-1:0] pages_done_second_select;
  logic [31:0] bad_block_capture_first_q;
  logic [31:0] bad_block_capture_second_q;
  logic [31:0] read_return_delay_q;
  logic [npbr_pkg::IRQ_W-1:0] irq_status_q;
  logic [npbr_pkg::IRQ_W-1:0] irq_enable_q;
  logic [npbr_pkg::IRQ_W-1:0] irq_event;
  logic [npbr_pkg::IRQ_W-1:0] irq_clear;
  logic [31:0] rdata_d;
  logic known;

  assign access = psel && penable;
  assign wr = access && pwrite;
  // Zero-wait slave
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // per-select counters
  npbr_page_counter #(.W(CNT_W)) u_cnt_first (
    .mclk(mclk),
    .nrst(nrst),
    .cmd_start(cmd_start_first),
    .page_done(page_done_first),
    .count_q(pages_done_first_select)
  );

  npbr_page_counter #(.W(CNT_W)) u_cnt_second (
    .mclk(mclk),
    .nrst(nrst),
    .cmd_start(cmd_start_second),
    .page_done(page_done_second),
    .count_q(pages_done_second_select)
  );

  ////////////////////////////////////////////////////////////////////////
  // capture on first- and second-select detection
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bad_block_capture_first_q <= npbr_pkg::RESET_WORD;
    end else if (bad_block_first) begin
      bad_block_capture_first_q <= addr_cycles;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bad_block_capture_second_q <= npbr_pkg::RESET_WORD;
    end else if (bad_block_second) begin
      bad_block_capture_second_q <= addr_cycles;
    end
  end

  assign bad_block_flag_first = irq_status_q[npbr_pkg::IRQ_BB0];
  assign bad_block_flag_second = irq_status_q[npbr_pkg::IRQ_BB1];

  ////////////////////////////////////////////////////////////////////////
  // resets to zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      read_return_delay_q <= npbr_pkg::RESET_WORD;
    end else if (wr && paddr == npbr_pkg::OFS_RET_DELAY) begin
      read_return_delay_q <= pwdata & npbr_pkg::RET_DELAY_MASK;
    end
  end

  npbr_delay_chain #(
    .STAGES(npbr_pkg::STAGES),
    .STAGE_W(npbr_pkg::STAGE_W),
    .SEL_W(npbr_pkg::SEL_W)
  ) u_chain (
    .mclk(mclk),
    .nrst(nrst),
    .strobe_in(read_strobe_n),
    .stage_set(read_return_delay_q[npbr_pkg::STAGES*npbr_pkg::STAGE_W-1:0]),
    .tap_sel(read_return_delay_q[npbr_pkg::SEL_LSB +: npbr_pkg::SEL_W]),
    .latch_edge(latch_edge)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    irq_event = '0;
    irq_event[npbr_pkg::IRQ_BB0] = bad_block_first;
    irq_event[npbr_pkg::IRQ_BB1] = bad_block_second;
    irq_event[npbr_pkg::IRQ_PG0] = page_done_first;
    irq_event[npbr_pkg::IRQ_PG1] = page_done_second;
  end

  assign irq_clear = (wr && paddr == npbr_pkg::OFS_IRQ_CLEAR) ?
                     pwdata[npbr_pkg::IRQ_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_enable_q <= '0;
    end else if (wr && paddr == npbr_pkg::OFS_IRQ_ENABLE) begin
      irq_enable_q <= pwdata[npbr_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  ////////////////////////////////////////////////////////////////////////
  // read decode; count and capture words read-only, writes to them ignored
  always_comb begin
    rdata_d = '0;
    known = 1'b1;
    case (paddr)
      npbr_pkg::OFS_PAGE_COUNT: begin
        rdata_d[npbr_pkg::CNT1_LSB +: CNT_W] = pages_done_second_select;
        rdata_d[npbr_pkg::CNT0_LSB +: CNT_W] = pages_done_first_select;
      end
      npbr_pkg::OFS_BB_FIRST: rdata_d = bad_block_capture_first_q;
      npbr_pkg::OFS_BB_SECOND: rdata_d = bad_block_capture_second_q;
      npbr_pkg::OFS_RET_DELAY: rdata_d = read_return_delay_q;
      npbr_pkg::OFS_IRQ_STATUS: rdata_d[npbr_pkg::IRQ_W-1:0] = irq_status_q;
      npbr_pkg::OFS_IRQ_CLEAR: rdata_d = '0;
      npbr_pkg::OFS_IRQ_ENABLE: rdata_d[npbr_pkg::IRQ_W-1:0] = irq_enable_q;
      default: known = 1'b0;
    endcase
  end

  // Data straight from the decode; pready never stalls
  assign prdata = (access && !pwrite) ? rdata_d : '0;
  assign pslverr = access && !known;
endmodule
`default_nettype wire

// File: sim/npbr_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module npbr_flash_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [2:0] req,
  input wire logic [31:0] addr_in,
  output logic cmd_start_first,
  output logic cmd_start_second,
  output logic page_done_first,
  output logic page_done_second,
  output logic bad_block_first,
  output logic bad_block_second,
  output logic [31:0] addr_cycles,
  output logic read_strobe_n
);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {cmd_start_first, cmd_start_second} <= 2'h0;
      {page_done_first, page_done_second} <= 2'h0;
      {bad_block_first, bad_block_second} <= 2'h0;
      addr_cycles <= 32'h0;
      read_strobe_n <= 1'b1;
    end else begin
      cmd_start_first <= req == 3'h1;
      cmd_start_second <= req == 3'h2;
      page_done_first <= req == 3'h3;
      page_done_second <= req == 3'h4;
      bad_block_first <= req == 3'h5;
      bad_block_second <= req == 3'h6;
      // Address only valid with the detection pulse
      addr_cycles <= (req == 3'h5 || req == 3'h6) ? addr_in : ~addr_in;
      read_strobe_n <= req != 3'h7;
    end
  end
endmodule
`default_nettype wire

// File: sim/npbr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module npbr_regs_monitor (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic bad_block_first,
  input wire logic bad_block_second,
  input wire logic [31:0] addr_cycles,
  input wire logic read_strobe_n,
  input wire logic latch_edge,
  input wire logic bad_block_flag_first
);
  logic acc, wr, rd, sel_hi_q;
  logic [31:0] cap_q;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sel_hi_q <= 1'b0;
      cap_q <= 32'h0;
    end else begin
      if (wr && paddr == 8'h0c) sel_hi_q <= pwdata[27];
      if (bad_block_first) cap_q <= addr_cycles;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////
  flag_set_a: assert property (bad_block_first |=> bad_block_flag_first)
    else $error("first flag not set");
  flag_hold_a: assert property (bad_block_flag_first &&
    !(wr && paddr == 8'h14 && pwdata[0]) |=> bad_block_flag_first)
    else $error("first flag lost");
  capture_read_a: assert property (rd && paddr == 8'h04 |-> prdata == cap_q)
    else $error("capture word wrong");
  count_rsv_a: assert property (rd && paddr == 8'h00 |->
    prdata[31:22] == 10'h0 && prdata[15:6] == 10'h0)
    else $error("count reserved bits set");
  delay_rsv_a: assert property (rd && paddr == 8'h0c |-> prdata[31:28] == 4'h0)
    else $error("delay reserved bits set");
  pass_thru_a: assert property (!sel_hi_q |-> latch_edge == read_strobe_n)
    else $error("undelayed strobe altered");
  unmapped_err_a: assert property (acc && paddr > 8'h18 |-> pslverr)
    else $error("no error on unmapped");
  mapped_ok_a: assert property (acc && paddr[1:0] == 2'h0 &&
    paddr <= 8'h18 |-> !pslverr)
    else $error("error on mapped");
  cover property (bad_block_second);
  cover property (sel_hi_q && !latch_edge);
  cover property (acc && pslverr);
endmodule
bind npbr_regs npbr_regs_monitor u_npbr_regs_monitor (.mclk(mclk),
  .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .bad_block_first(bad_block_first), .bad_block_second(bad_block_second),
  .addr_cycles(addr_cycles), .read_strobe_n(read_strobe_n),
  .latch_edge(latch_edge), .bad_block_flag_first(bad_block_flag_first));
`default_nettype wire

// File: sim/nand_page_badblock_redelay_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module nand_page_badblock_redelay_regs_tb_top;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, e;} npbr_row_t;
  localparam npbr_row_t ROWS[17] = '{'{0, 8'h00, 0, 0}, '{0, 8'h04, 0, 0},
    '{0, 8'h08, 0, 0}, '{0, 8'h0c, 0, 0}, '{1, 8'h0c, 32'hffffffff, 0},
    '{0, 8'h0c, 0, 32'h0fffffff}, '{1, 8'h00, 32'hffffffff, 0},
    '{0, 8'h00, 0, 0}, '{1, 8'h04, 32'hffffffff, 0}, '{0, 8'h04, 0, 0},
    '{1, 8'h08, 32'hffffffff, 0}, '{0, 8'h08, 0, 0}, '{0, 8'h1c, 0, 0},
    '{1, 8'h18, 32'hf, 0}, '{0, 8'h18, 0, 32'hf},
    '{1, 8'h0c, 32'h08000002, 0}, '{0, 8'h0c, 0, 32'h08000002}};
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, addr_in = 0, prdata, ac, r;
  logic [2:0] req = 0;
  logic pready, pslverr, s, latch_edge, ff0, ff1, irq;
  logic cs0, cs1, pd0, pd1, bb0, bb1, rs_n;
  int err_count = 0, n_compared = 0;
  always #12.5 mclk = ~mclk;
  npbr_flash_model u_npbr_flash_model (.mclk(mclk), .nrst(nrst), .req(req),
    .addr_in(addr_in), .cmd_start_first(cs0), .cmd_start_second(cs1),
    .page_done_first(pd0), .page_done_second(pd1), .bad_block_first(bb0),
    .bad_block_second(bb1), .addr_cycles(ac), .read_strobe_n(rs_n));
  npbr_regs u_npbr_regs (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_start_first(cs0), .cmd_start_second(cs1), .page_done_first(pd0),
    .page_done_second(pd1), .bad_block_first(bb0), .bad_block_second(bb1),
    .addr_cycles(ac), .read_strobe_n(rs_n), .latch_edge(latch_edge),
    .bad_block_flag_first(ff0), .bad_block_flag_second(ff1), .irq(irq));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Model pulses one cycle late; two spare edges let it land
  task automatic ev(input logic [2:0] c);
    req <= c;
    @(posedge mclk);
    req <= 3'h0;
    repeat (2) @(posedge mclk);
  endtask
  task close_out;
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    foreach (ROWS[i]) begin
      apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].w) chk(r, ROWS[i].e);
      chk(32'(s), 32'(ROWS[i].a == 8'h1c));
      chk(32'(pready), 32'h1);
    end
    ev(3'h1);
    repeat (3) ev(3'h3);
    ev(3'h2);
    repeat (2) ev(3'h4);
    apb(0, 8'h00, 0);
    chk(r, 32'h00020003);
    chk(32'(irq), 32'h1);
    ev(3'h1);
    apb(0, 8'h00, 0);
    chk(r, 32'h00020000);
    apb(1, 8'h14, 32'hf);
    apb(1, 8'h18, 32'h2);
    addr_in <= 32'h5a4b3c2d;
    ev(3'h5);
    chk(32'(ff0), 32'h1);
    chk(32'(irq), 32'h0);
    addr_in <= 32'h11223344;
    ev(3'h6);
    chk(32'({ff1, irq}), 32'h3);
    apb(0, 8'h04, 0);
    chk(r, 32'h5a4b3c2d);
    apb(0, 8'h08, 0);
    chk(r, 32'h11223344);
    apb(0, 8'h10, 0);
    chk(r, 32'h3);
    // Tap 8 with setting 2: several cycles of lag
    req <= 3'h7;
    repeat (3) @(posedge mclk);
    #1 chk(32'(latch_edge), 32'h1);
    repeat (5) @(posedge mclk);
    #1 chk(32'(latch_edge), 32'h0);
    @(posedge mclk);
    req <= 3'h0;
    // Mid-run reset must bring the delay word back to zero
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    apb(0, 8'h0c, 0);
    chk(r, 32'h0);
    apb(0, 8'h04, 0);
    chk(r, 32'h0);
    close_out;
  end
  initial begin
    #50000;
    err_count++;
    close_out;
  end
endmodule
`default_nettype wire
